// file: hdl/shcs_port.sv
// shcs_port: command slot engine of one sata port
// assumes: register port from local logic, device status from pins,
// memory reads done by an outside bus master on request/ack.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module shcs_port
	import shcs_pkg::*;
#(
	parameter bit HAS_LIST  = 1'b1,
	parameter bit HAS_NCQ   = 1'b1,
	parameter bit HAS_ADDR64 = 1'b1
)(
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              clkEn,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdata,
	input  wire logic              devBusyPin,
	input  wire logic              devDrqPin,
	input  wire logic              devErrPin,
	output logic                   fetchReq,
	output logic      [63:0]       fetchAddr,
	input  wire logic              fetchAck,
	input  wire logic [DATA_W-1:0] fetchInfo,
	input  wire logic [63:0]       fetchTable,
	output logic                   cmdSend,
	output logic      [SLOT_W-1:0] cmdSlot,
	output logic      [63:0]       cmdTable,
	output logic      [DATA_W-1:0] cmdInfo,
	output logic      [PMP_W-1:0]  cmdPmp,
	input  wire logic              cmdSent,
	input  wire logic              setupValid,
	input  wire logic [SLOT_W-1:0] setupTag,
	output logic      [SLOT_W-1:0] xferSlot,
	output logic                   xferValid,
	input  wire logic              queuedDone,
	input  wire logic [SLOT_W-1:0] queuedDoneTag
);
	// ========================================
	// pin synchronisers
	logic devBusy;
	logic devDrq;
	logic devErr;

	shcs_sync uBusy (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.pinIn   (devBusyPin),
		.syncOut (devBusy)
	);
	shcs_sync uDrq (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.pinIn   (devDrqPin),
		.syncOut (devDrq)
	);
	shcs_sync uErr (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.pinIn   (devErrPin),
		.syncOut (devErr)
	);

	// ========================================
	// register state
	logic                  run_q,      run_d;
	logic                  queued_q,   queued_d;
	logic [PMP_W-1:0]      pmp_q,      pmp_d;
	logic [NUM_SLOTS-1:0]  issue_q,    issue_d;
	logic [NUM_SLOTS-1:0]  qact_q,     qact_d;
	logic [DATA_W-1:0]     base_q,     base_d;
	logic [DATA_W-1:0]     baseU_q,    baseU_d;
	logic [DATA_W-1:0]     rdata_q,    rdata_d;
	logic                  errFlag;
	logic                  errSet;
	logic                  errClr;

	// ========================================
	// engine state
	shcs_state_t           state_q,    state_d;
	logic [SLOT_W-1:0]     slot_q,     slot_d;
	logic [3:0]            settle_q,   settle_d;
	logic                  fReq_q,     fReq_d;
	logic [63:0]           fAddr_q,    fAddr_d;
	logic                  send_q,     send_d;
	logic [63:0]           table_q,    table_d;
	logic [DATA_W-1:0]     info_q,     info_d;
	logic [SLOT_W-1:0]     xSlot_q,    xSlot_d;
	logic                  xValid_q,   xValid_d;

	logic                  wrCmd;
	logic                  wrIssue;
	logic                  devIdle;
	logic [NUM_SLOTS-1:0]  slotMask;
	logic [NUM_SLOTS-1:0]  pendMask;
	logic                  pendAny;
	logic [SLOT_W-1:0]     pendIdx;

	assign wrCmd   = regWr && (regAddr == OFF_CMD);
	assign wrIssue = regWr && (regAddr == OFF_ISSUE);
	assign errClr  = regWr && (regAddr == OFF_ERRSTAT) && regWdata[0];
	assign errSet  = (state_q == ST_WAIT) && devErr;
	assign devIdle = !devBusy && !devDrq && !devErr;

	// without a list only slot 0 exists
	assign slotMask = HAS_LIST ? {NUM_SLOTS{1'b1}} : NUM_SLOTS'(1);

	shcs_w1c_bit uErrFlag (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.clkEn   (clkEn),
		.setIn   (errSet),
		.clrIn   (errClr),
		.flagOut (errFlag)
	);

	// ========================================
	// lowest pending slot not yet sent
	always_comb begin
		pendMask = issue_q & slotMask;
		pendAny  = |pendMask;
		pendIdx  = '0;
		for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
			if (pendMask[i])
				pendIdx = SLOT_W'(i);
		end
	end

	// ========================================
	// register next state
	always_comb begin
		run_d    = run_q;
		queued_d = queued_q;
		pmp_d    = pmp_q;
		issue_d  = issue_q;
		qact_d   = qact_q;
		base_d   = base_q;
		baseU_d  = baseU_q;
		if (wrCmd) begin
			run_d    = regWdata[CMD_RUN_BIT];
			queued_d = HAS_NCQ && regWdata[CMD_QUEUED_BIT];
			pmp_d    = regWdata[CMD_PMP_LSB +: PMP_W];
		end
		if (regWr && (regAddr == OFF_LISTBASE))
			base_d = {regWdata[DATA_W-1:10], 10'h000};
		if (regWr && (regAddr == OFF_LISTBASEU) && HAS_ADDR64)
			baseU_d = regWdata;
		// hardware clears after send, before software sets
		if (state_q == ST_SEND && cmdSent)
			issue_d[slot_q] = 1'b0;
		if (queuedDone && queued_q)
			qact_d[queuedDoneTag] = 1'b0;
		if (wrIssue && run_q) begin
			issue_d = issue_d | (regWdata & slotMask);
			if (queued_q)
				qact_d = qact_d | (regWdata & slotMask);
		end
		if (!run_d) begin
			issue_d = '0;
			qact_d  = '0;
		end
	end

	// ========================================
	// read mux
	always_comb begin
		rdata_d = RST_WORD;
		if (regRd) begin
			unique case (regAddr)
				OFF_CMD: begin
					rdata_d[CMD_RUN_BIT]             = run_q;
					rdata_d[CMD_QUEUED_BIT]          = queued_q;
					rdata_d[CMD_PMP_LSB +: PMP_W]    = pmp_q;
				end
				OFF_ISSUE:     rdata_d = issue_q;
				OFF_QACT:      rdata_d = qact_q;
				OFF_ERRSTAT:   rdata_d[0] = errFlag;
				OFF_LISTBASE:  rdata_d = base_q;
				OFF_LISTBASEU: rdata_d = baseU_q;
				OFF_STATUS: begin
					rdata_d[ST_BUSY_BIT]             = devBusy;
					rdata_d[ST_DRQ_BIT]              = devDrq;
					rdata_d[ST_ERR_BIT]              = devErr;
					rdata_d[ST_ENGINE_BIT]           = (state_q != ST_IDLE);
					rdata_d[ST_SLOT_LSB +: SLOT_W]   = slot_q;
				end
				OFF_CAP: begin
					rdata_d[CAP_SLOTS_LSB +: SLOT_W] = HAS_LIST ? CAP_NSLOTS : '0;
					rdata_d[CAP_64_BIT]              = HAS_ADDR64;
					rdata_d[CAP_NCQ_BIT]             = HAS_NCQ;
					rdata_d[CAP_LIST_BIT]            = HAS_LIST;
				end
				default:       rdata_d = RST_WORD;
			endcase
		end
	end

	// ========================================
	// command walk
	always_comb begin
		state_d  = state_q;
		slot_d   = slot_q;
		settle_d = settle_q;
		fReq_d   = fReq_q;
		fAddr_d  = fAddr_q;
		send_d   = send_q;
		table_d  = table_q;
		info_d   = info_q;
		xSlot_d  = xSlot_q;
		xValid_d = 1'b0;
		if (setupValid && queued_q) begin
			xSlot_d  = setupTag;
			xValid_d = 1'b1;
		end
		unique case (state_q)
			ST_IDLE: begin
				if (run_q && pendAny) begin
					slot_d  = pendIdx;
					fReq_d  = 1'b1;
					fAddr_d = {HAS_ADDR64 ? baseU_q : RST_WORD, base_q}
						+ {51'h0, pendIdx, 8'h00};
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (fetchAck) begin
					fReq_d  = 1'b0;
					info_d  = fetchInfo;
					// pointer to descriptor table with regions
					table_d = HAS_ADDR64 ? fetchTable : {32'h0, fetchTable[31:0]};
					send_d  = 1'b1;
					state_d = ST_SEND;
				end
			end
			ST_SEND: begin
				if (cmdSent) begin
					send_d   = 1'b0;
					settle_d = SETTLE_CNT;
					state_d  = queued_q ? ST_DONE : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (settle_q != 4'h0)
					settle_d = settle_q - 4'h1;
				else if (devIdle)
					state_d = ST_DONE;
			end
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
		if (!run_q) begin
			state_d = ST_IDLE;
			fReq_d  = 1'b0;
			send_d  = 1'b0;
		end
	end

	// ========================================
	// registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			run_q    <= 1'b0;
			queued_q <= 1'b0;
			pmp_q    <= RST_PMP;
			issue_q  <= '0;
			qact_q   <= '0;
			base_q   <= RST_WORD;
			baseU_q  <= RST_WORD;
			rdata_q  <= RST_WORD;
			state_q  <= ST_IDLE;
			slot_q   <= '0;
			settle_q <= 4'h0;
			fReq_q   <= 1'b0;
			fAddr_q  <= 64'h0;
			send_q   <= 1'b0;
			table_q  <= 64'h0;
			info_q   <= RST_WORD;
			xSlot_q  <= '0;
			xValid_q <= 1'b0;
		end else if (clkEn) begin
			run_q    <= run_d;
			queued_q <= queued_d;
			pmp_q    <= pmp_d;
			issue_q  <= issue_d;
			qact_q   <= qact_d;
			base_q   <= base_d;
			baseU_q  <= baseU_d;
			rdata_q  <= rdata_d;
			state_q  <= state_d;
			slot_q   <= slot_d;
			settle_q <= settle_d;
			fReq_q   <= fReq_d;
			fAddr_q  <= fAddr_d;
			send_q   <= send_d;
			table_q  <= table_d;
			info_q   <= info_d;
			xSlot_q  <= xSlot_d;
			xValid_q <= xValid_d;
		end
	end

	assign regRdata  = rdata_q;
	assign fetchReq  = fReq_q;
	assign fetchAddr = fAddr_q;
	assign cmdSend   = send_q;
	assign cmdSlot   = slot_q;
	assign cmdTable  = table_q;
	assign cmdInfo   = info_q;
	assign cmdPmp    = pmp_q;
	assign xferSlot  = xSlot_q;
	assign xferValid = xValid_q;
endmodule : shcs_port

// file: hdl/shcs_pkg.sv
// shcs_pkg: constants for the command slot engine of one sata port
// assumes: a 100 mhz sys_clk, word-wide register port
package shcs_pkg;
	localparam int NUM_SLOTS = 32;
	localparam int SLOT_W    = 5;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;

	// ========================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_CMD       = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_ISSUE     = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_QACT      = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ERRSTAT   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_LISTBASE  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_LISTBASEU = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CAP       = 8'h1c;

	// ========================================
	// field positions
	localparam int CMD_RUN_BIT    = 0;
	localparam int CMD_QUEUED_BIT = 1;
	localparam int CMD_PMP_LSB    = 8;
	localparam int PMP_W          = 4;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_DRQ_BIT     = 1;
	localparam int ST_ERR_BIT     = 2;
	localparam int ST_ENGINE_BIT  = 3;
	localparam int ST_SLOT_LSB    = 8;
	localparam int CAP_SLOTS_LSB  = 8;
	localparam int CAP_64_BIT     = 31;
	localparam int CAP_NCQ_BIT    = 30;
	localparam int CAP_LIST_BIT   = 29;

	// ========================================
	// reset values and fixed capabilities
	localparam logic [DATA_W-1:0] RST_WORD   = 32'h0000_0000;
	localparam logic [PMP_W-1:0]  RST_PMP    = 4'h0;
	localparam logic [SLOT_W-1:0] CAP_NSLOTS = 5'h1f;

	// ========================================
	// timing
	localparam int CLK_MHZ       = 100;
	localparam int SETTLE_NS     = 20;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYCLES);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_SEND,
		ST_WAIT,
		ST_DONE
	} shcs_state_t;
endpackage : shcs_pkg

// file: hdl/shcs_sync.sv
// shcs_sync: two-stage synchroniser for one pin level
// assumes: input arrives from outside the sys_clk domain
`timescale 1ns/10ps
module shcs_sync
	import shcs_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic pinIn,
	output logic      syncOut
);
	logic stage1_q;
	logic stage2_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stage1_q <= 1'b0;
			stage2_q <= 1'b0;
		end else if (clkEn) begin
			stage1_q <= pinIn;
			stage2_q <= stage1_q;
		end
	end

	assign syncOut = stage2_q;
endmodule : shcs_sync

// file: hdl/shcs_w1c_bit.sv
// shcs_w1c_bit: one sticky status bit, hardware set, write-one clear
// assumes: set and clear come from logic on sys_clk
`timescale 1ns/10ps
module shcs_w1c_bit
	import shcs_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic setIn,
	input  wire logic clrIn,
	output logic      flagOut
);
	logic flag_q;
	logic flag_d;

	// set wins over a clear in the same cycle
	always_comb begin
		flag_d = flag_q;
		if (clrIn)
			flag_d = 1'b0;
		if (setIn)
			flag_d = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			flag_q <= 1'b0;
		else if (clkEn)
			flag_q <= flag_d;
	end

	assign flagOut = flag_q;
endmodule : shcs_w1c_bit

// file: bench/shcs_port_chk.sv
// shcs_port_chk: timing checks on the port engine
// assumes: bound onto every shcs_port
`timescale 1ns/10ps
module shcs_port_chk
	import shcs_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              resetn,
	input wire logic              regWr,
	input wire logic              regRd,
	input wire logic [DATA_W-1:0] regRdata,
	input wire logic              fetchReq,
	input wire logic [63:0]       fetchAddr,
	input wire logic              fetchAck,
	input wire logic [DATA_W-1:0] fetchInfo,
	input wire logic [63:0]       fetchTable,
	input wire logic              cmdSend,
	input wire logic [63:0]       cmdTable,
	input wire logic [DATA_W-1:0] cmdInfo,
	input wire logic              cmdSent,
	input wire logic              setupValid,
	input wire logic [SLOT_W-1:0] setupTag,
	input wire logic [SLOT_W-1:0] xferSlot,
	input wire logic              xferValid
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// ========================================
	// sequences
	sequence s_ack;
		fetchReq && fetchAck && !regWr && !$past(regWr);
	endsequence
	sequence s_hold;
		fetchReq && !fetchAck && !regWr && !$past(regWr);
	endsequence
	// ========================================
	// properties
	property p_rdZero; !regRd |=> regRdata == RST_WORD; endproperty
	property p_fetchHold; s_hold |=> fetchReq; endproperty
	property p_ackSend; s_ack |=> cmdSend && !fetchReq; endproperty
	property p_table;
		s_ack |=> cmdTable == $past(fetchTable) && cmdInfo == $past(fetchInfo);
	endproperty
	property p_sendHold;
		cmdSend && !cmdSent && !regWr && !$past(regWr) |=> cmdSend;
	endproperty
	property p_sentDrop; cmdSend && cmdSent |=> !cmdSend && !fetchReq; endproperty
	property p_echo;
		xferValid |-> $past(setupValid) && xferSlot == $past(setupTag);
	endproperty
	property p_align; fetchReq |-> fetchAddr[7:0] == 8'h00; endproperty
	property p_rstQuiet; $rose(resetn) |-> !fetchReq && !cmdSend && !xferValid; endproperty
	a_rdZero: assert property (p_rdZero) else $error("read data outside read slot");
	a_fetchHold: assert property (p_fetchHold) else $error("fetch dropped");
	a_ackSend: assert property (p_ackSend) else $error("no send after fetch");
	a_table: assert property (p_table) else $error("entry data lost");
	a_sendHold: assert property (p_sendHold) else $error("send dropped");
	a_sentDrop: assert property (p_sentDrop) else $error("send held");
	a_echo: assert property (p_echo) else $error("bad transfer slot");
	a_align: assert property (p_align) else $error("slot address skew");
	a_rstQuiet: assert property (p_rstQuiet) else $error("busy after reset");
endmodule : shcs_port_chk

bind shcs_port shcs_port_chk chk_u (.sys_clk(sys_clk), .resetn(resetn), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
	.fetchAck(fetchAck), .fetchInfo(fetchInfo), .fetchTable(fetchTable),
	.cmdSend(cmdSend), .cmdTable(cmdTable), .cmdInfo(cmdInfo), .cmdSent(cmdSent),
	.setupValid(setupValid), .setupTag(setupTag), .xferSlot(xferSlot),
	.xferValid(xferValid));

// file: bench/shcs_dev_model.sv
// shcs_dev_model: memory and device stand-in for the port engine
// assumes: one sys_clk; slow stretches every answer
`timescale 1ns/10ps
module shcs_dev_model
(
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        slow,
	input  wire logic        fetchReq,
	input  wire logic [63:0] fetchAddr,
	output logic             fetchAck,
	output logic [31:0]      fetchInfo,
	output logic [63:0]      fetchTable,
	input  wire logic        cmdSend,
	output logic             cmdSent,
	output logic             devBusyPin,
	output logic             devDrqPin
);
	logic [2:0]  wait_q;
	logic [2:0]  busy_q;
	logic [31:0] info;
	logic [63:0] tbl;
	// ========================================
	// entry data, inverted outside the ack cycle
	assign info       = fetchAddr[31:0] ^ 32'h0bad_0f0d;
	assign tbl        = {32'h0, fetchAddr[31:0] + 32'h80};
	assign fetchInfo  = fetchAck ? info : ~info;
	assign fetchTable = fetchAck ? tbl : ~tbl;
	assign devBusyPin = busy_q != 3'h0;
	assign devDrqPin  = busy_q > 3'h3;
	// ========================================
	// answers
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fetchAck <= 1'b0;
			cmdSent  <= 1'b0;
			wait_q   <= 3'h0;
			busy_q   <= 3'h0;
		end else begin
			fetchAck <= 1'b0;
			cmdSent  <= 1'b0;
			if (busy_q != 3'h0) busy_q <= busy_q - 3'h1;
			if ((fetchReq && !fetchAck) || (cmdSend && !cmdSent)) begin
				wait_q <= wait_q + 3'h1;
				if (wait_q >= (slow ? 3'h4 : 3'h0)) begin
					wait_q   <= 3'h0;
					fetchAck <= fetchReq;
					cmdSent  <= cmdSend;
					if (cmdSend) busy_q <= 3'h6;
				end
			end
		end
	end
endmodule : shcs_dev_model

// file: bench/shcs_port_tb_top.sv
// shcs_port_tb_top: self-checking bench for shcs_port
// assumes: shcs_dev_model as memory and device
`timescale 1ns/10ps
module shcs_port_tb_top
	import shcs_pkg::*;
;
	localparam logic [31:0] BASE = 32'h0000_1000;
	logic sys_clk, resetn, regWr, regRd, devErrPin, setupValid, queuedDone, slow, qMode, rdPrev;
	logic fetchReq, fetchAck, cmdSend, cmdSent, devBusyPin, devDrqPin, xferValid;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWdata, regRdata, fetchInfo, cmdInfo, rnd;
	logic [SLOT_W-1:0] setupTag, queuedDoneTag, cmdSlot, xferSlot;
	logic [63:0] fetchAddr, fetchTable, cmdTable;
	logic [PMP_W-1:0] cmdPmp;
	logic [63:0] expQ[$];
	logic [SLOT_W-1:0] slotQ[$];
	logic [SLOT_W-1:0] tagQ[$];
	logic [ADDR_W-1:0] zeroOffs [5] = '{OFF_CMD, OFF_ISSUE, OFF_QACT, OFF_ERRSTAT, OFF_STATUS};
	int badCount, nTests;
	shcs_port dut_u (.sys_clk(sys_clk), .resetn(resetn), .clkEn(1'b1), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.devBusyPin(devBusyPin), .devDrqPin(devDrqPin), .devErrPin(devErrPin),
		.fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck),
		.fetchInfo(fetchInfo), .fetchTable(fetchTable), .cmdSend(cmdSend),
		.cmdSlot(cmdSlot), .cmdTable(cmdTable), .cmdInfo(cmdInfo), .cmdPmp(cmdPmp),
		.cmdSent(cmdSent), .setupValid(setupValid), .setupTag(setupTag),
		.xferSlot(xferSlot), .xferValid(xferValid), .queuedDone(queuedDone),
		.queuedDoneTag(queuedDoneTag));
	shcs_dev_model dev_u (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
		.fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchAck(fetchAck),
		.fetchInfo(fetchInfo), .fetchTable(fetchTable), .cmdSend(cmdSend),
		.cmdSent(cmdSent), .devBusyPin(devBusyPin), .devDrqPin(devDrqPin));
	// ========================================
	// tasks
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		nTests++;
		if (g !== e) begin
			badCount++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		regRd    <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		expQ.push_back({32'h0, e});
		regAddr <= a;
		regRd   <= 1'b1;
		regWr   <= 1'b0;
		@(posedge sys_clk);
	endtask : rd
	task automatic idle(input int n);
		regWr      <= 1'b0;
		regRd      <= 1'b0;
		setupValid <= 1'b0;
		queuedDone <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask : idle
	task automatic drain;
		idle(1);
		for (int k = 0; k < 3000 && slotQ.size() != 0; k++) @(posedge sys_clk);
		if (slotQ.size() != 0) badCount++;
		repeat (12) @(posedge sys_clk);
	endtask : drain
	task automatic giveVerdict;
		$display("comparisons %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : giveVerdict
	// ========================================
	// clock, watchdog, monitor
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (30000) @(posedge sys_clk);
		badCount++;
		giveVerdict();
	end
	always @(posedge sys_clk) rdPrev <= regRd;
	always @(negedge sys_clk) begin
		if (rdPrev) chk("regRdata", expQ.pop_front(), {32'h0, regRdata});
		if (fetchReq && devBusyPin && !qMode) chk("advance", 64'h0, 64'h1);
		if (cmdSend && cmdSent) begin
			chk("cmdTable", {32'h0, BASE + {19'h0, slotQ[0], 8'h00} + 32'h80}, cmdTable);
			chk("cmdPmp", 64'h5, {60'h0, cmdPmp});
			chk("cmdInfo", {32'h0, BASE + {19'h0, slotQ[0], 8'h00} ^ 32'h0bad_0f0d},
				{32'h0, cmdInfo});
			chk("cmdSlot", {59'h0, slotQ.pop_front()}, {59'h0, cmdSlot});
		end
		if (xferValid) chk("xferSlot", {59'h0, tagQ.pop_front()}, {59'h0, xferSlot});
	end
	// ========================================
	// scenarios
	initial begin
		{resetn, regWr, regRd, devErrPin, setupValid, queuedDone, slow, qMode} = 8'h00;
		{regAddr, regWdata, setupTag, queuedDoneTag} = '0;
		rnd = 32'h0001_5d61;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		foreach (zeroOffs[i])
			rd(zeroOffs[i], 32'h0);
		rd(OFF_CAP, 32'he000_1f00);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
		wr(OFF_LISTBASE, 32'hffff_ffff);
		rd(OFF_LISTBASE, 32'hffff_fc00);
		wr(OFF_LISTBASEU, 32'h1);
		rd(OFF_LISTBASEU, 32'h1);
		wr(OFF_LISTBASEU, 32'h0);
		wr(OFF_ISSUE, 32'h1);
		rd(OFF_ISSUE, 32'h0);
		devErrPin <= 1'b1;
		idle(4);
		devErrPin <= 1'b0;
		idle(4);
		// error outside a command wait is not latched
		rd(OFF_ERRSTAT, 32'h0);
		wr(OFF_LISTBASE, BASE);
		wr(OFF_CMD, 32'h0000_0501);
		for (int p = 0; p < 2; p++) begin
			slow <= p[0];
			rnd = lfsr(rnd);
			for (int b = 0; b < 8; b++) if (rnd[b] || b == 0) slotQ.push_back(5'(b));
			devErrPin <= !p[0];
			wr(OFF_ISSUE, {24'h0, rnd[7:1], 1'b1});
			rd(OFF_ISSUE, {24'h0, rnd[7:1], 1'b1});
			idle(20);
			devErrPin <= 1'b0;
			drain();
			rd(OFF_ISSUE, 32'h0);
		end
		rd(OFF_ERRSTAT, 32'h1);
		wr(OFF_ERRSTAT, 32'h0);
		rd(OFF_ERRSTAT, 32'h1);
		wr(OFF_ERRSTAT, 32'h1);
		rd(OFF_ERRSTAT, 32'h0);
		qMode <= 1'b1;
		wr(OFF_CMD, 32'h0000_0503);
		slotQ.push_back(5'h0);
		slotQ.push_back(5'h2);
		wr(OFF_ISSUE, 32'h5);
		rd(OFF_QACT, 32'h5);
		drain();
		rd(OFF_QACT, 32'h5);
		regRd      <= 1'b0;
		setupValid <= 1'b1;
		setupTag   <= 5'h02;
		tagQ.push_back(5'h02);
		@(posedge sys_clk);
		setupValid    <= 1'b0;
		queuedDone    <= 1'b1;
		queuedDoneTag <= 5'h00;
		@(posedge sys_clk);
		queuedDoneTag <= 5'h02;
		@(posedge sys_clk);
		idle(1);
		rd(OFF_QACT, 32'h0);
		wr(OFF_CMD, 32'h0000_0001);
		wr(OFF_ISSUE, 32'h8);
		wr(OFF_CMD, 32'h0);
		idle(3);
		rd(OFF_ISSUE, 32'h0);
		idle(4);
		chk("xferLeft", 64'h0, 64'(tagQ.size()));
		giveVerdict();
	end
endmodule : shcs_port_tb_top
